// *** core/sblp_pkg.sv ***
package sblp_pkg;

  // ==========================================================================
  // Handshake bytes
  localparam logic [7:0] ACK_BYTE = 8'hCC;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ==========================================================================
  // Command codes and their packet lengths
  localparam logic [7:0] CMD_PING     = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN      = 8'h22;
  localparam logic [7:0] CMD_STATUS   = 8'h23;
  localparam logic [7:0] CMD_DATA     = 8'h24;
  localparam logic [7:0] CMD_RESET    = 8'h25;
  localparam logic [7:0] LEN_SHORT    = 8'h03;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0B;
  localparam logic [7:0] LEN_RUN      = 8'h07;
  localparam logic [7:0] LEN_HEADER   = 8'h02;

  // ==========================================================================
  // Buffer sizing: command byte plus at most nine more bytes; data packets carry at most eight
  localparam int         PAYLOAD_MAX   = 10;
  localparam logic [7:0] DATA_MAX      = 8'h08;

  // ==========================================================================
  // Last-command status codes (values are implementation defined)
  localparam logic [7:0] STAT_SUCCESS  = 8'h40;
  localparam logic [7:0] STAT_UNKNOWN  = 8'h41;
  localparam logic [7:0] STAT_INVALID  = 8'h42;
  localparam logic [7:0] STAT_BAD_SIZE = 8'h43;
  localparam logic [7:0] STAT_RESET    = 8'h00;

  // ==========================================================================
  // Synchronous port framing
  localparam logic CLOCK_PHASE    = 1'b1;
  localparam logic CLOCK_POLARITY = 1'b1;

  // ==========================================================================
  // Action held back until the acknowledge byte has left
  localparam logic [2:0] PEND_NONE  = 3'h0;
  localparam logic [2:0] PEND_PROG  = 3'h1;
  localparam logic [2:0] PEND_RUN   = 3'h2;
  localparam logic [2:0] PEND_RST   = 3'h3;
  localparam logic [2:0] PEND_REPLY = 3'h4;

  // ==========================================================================
  // Main sequencer states
  typedef enum logic [8:0] {
    S_IDLE     = 9'h001,
    S_SUM      = 9'h002,
    S_DATA     = 9'h004,
    S_CHECK    = 9'h008,
    S_ERASE    = 9'h010,
    S_ACK      = 9'h020,
    S_PROG     = 9'h040,
    S_REPLY    = 9'h080,
    S_HOST_ACK = 9'h100
  } sblp_state_t;

endpackage

// *** core/sblp_fifo.sv ***
`timescale 1ns/100ps

module sblp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output      logic             o_in_ready,
  // Drain side
  output      logic             o_out_valid,
  output      logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } sblp_fifo_st_t;

  sblp_fifo_st_t r, n;
  logic          push;
  logic          pop;

  // ==========================================================================
  // Next state; flags are registered so ready comes straight from a flop
  always_comb begin
    n    = r;
    push = i_in_valid && !r.full;
    pop  = i_out_ready && !r.empty;
    if (push) begin
      n.mem[r.wp] = i_in_data;
      n.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt   = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    n.full  = (n.cnt == (AW+1)'(DEPTH));
    n.empty = (n.cnt == '0);
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r       <= '0;
      r.empty <= 1'b1;
      // Reads as full in reset so no byte is offered to a buffer that drops it
      r.full  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_in_ready  = !r.full;
  assign o_out_valid = !r.empty;
  assign o_out_data  = r.mem[r.rp];

endmodule

// *** core/sblp_loader.sv ***
`timescale 1ns/100ps

module sblp_loader #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Received bytes from the serial port
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output      logic        o_rx_ready,
  // Bytes to the serial port
  output      logic        o_tx_valid,
  output      logic [7:0]  o_tx_data,
  input  wire logic        i_tx_ready,
  // Baud pattern detected by the serial port
  input  wire logic        i_baud_lock,
  // Flash engine
  output      logic        o_erase_valid,
  output      logic        o_prog_valid,
  output      logic [31:0] o_flash_addr,
  output      logic [31:0] o_flash_size,
  output      logic [7:0]  o_prog_data,
  input  wire logic        i_flash_done,
  // Execution control
  output      logic        o_run_valid,
  output      logic [31:0] o_run_addr,
  output      logic        o_soft_reset,
  // Port setup and state
  output      logic        o_clock_phase,
  output      logic        o_clock_polarity,
  output      logic [7:0]  o_status
);

  import sblp_pkg::*;

  typedef struct packed {
    sblp_state_t                   state;
    logic [7:0]                    len;
    logic [7:0]                    remain;
    logic [7:0]                    sum;
    logic [7:0]                    calc;
    logic [7:0]                    cnt;
    logic [PAYLOAD_MAX-1:0][7:0]   pbuf;
    logic [2:0]                    pend;
    logic [7:0]                    status;
    logic [7:0]                    reply;
    logic [1:0]                    rep_idx;
    logic [7:0]                    prog_idx;
    logic                          dl_active;
    logic [31:0]                   prog_addr;
    logic [31:0]                   prog_left;
    logic                          sync_pend;
    logic                          tx_valid;
    logic [7:0]                    tx_data;
    logic                          erase_valid;
    logic                          prog_valid;
    logic [31:0]                   flash_addr;
    logic [31:0]                   flash_size;
    logic [7:0]                    prog_data;
    logic                          run_valid;
    logic [31:0]                   run_addr;
    logic                          soft_reset;
    logic                          phase;
    logic                          polarity;
  } sblp_st_t;

  sblp_st_t    r, n;
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_ready;
  logic [7:0]  cmd;
  logic [7:0]  nbytes;
  logic [31:0] arg_a;
  logic [31:0] arg_b;

  // ==========================================================================
  // Reset release through two flops
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // Receive buffer; its full flag stalls the serial port
  sblp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (rst_n),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready)
  );

  // Parameter fields of the buffered payload, MSB first
  assign cmd    = r.pbuf[0];
  assign arg_a  = {r.pbuf[1], r.pbuf[2], r.pbuf[3], r.pbuf[4]};
  assign arg_b  = {r.pbuf[5], r.pbuf[6], r.pbuf[7], r.pbuf[8]};
  assign nbytes = r.cnt - 8'h01;

  // ==========================================================================
  // Sequencer
  always_comb begin
    n            = r;
    f_ready      = 1'b0;
    n.run_valid  = 1'b0;
    n.soft_reset = 1'b0;
    // A lock pulse in the clearing cycle is kept
    n.sync_pend  = r.sync_pend | i_baud_lock;
    unique case (r.state)
      S_IDLE: begin
        f_ready = 1'b1;
        // Only the baud answer can be in flight here
        if (r.tx_valid && i_tx_ready) begin
          n.tx_valid = 1'b0;
        end else if (!r.tx_valid && r.sync_pend) begin
          n.tx_valid  = 1'b1;
          n.tx_data   = ACK_BYTE;
          n.sync_pend = i_baud_lock;
        end
        // Leading zeros are padding, not a length
        if (f_valid && f_data != PAD_BYTE) begin
          n.len  = f_data;
          n.calc = 8'h00;
          n.cnt  = 8'h00;
          n.pbuf = '0;
          if (f_data < LEN_HEADER) begin
            n.pend     = PEND_NONE;
            n.status   = STAT_BAD_SIZE;
            n.tx_valid = 1'b1;
            n.tx_data  = NAK_BYTE;
            n.state    = S_ACK;
          end else begin
            n.state = S_SUM;
          end
        end
      end
      S_SUM: begin
        f_ready = 1'b1;
        if (f_valid) begin
          n.sum    = f_data;
          n.remain = r.len - LEN_HEADER;
          n.state  = (r.len == LEN_HEADER) ? S_CHECK : S_DATA;
        end
      end
      S_DATA: begin
        f_ready = 1'b1;
        if (f_valid) begin
          n.calc   = r.calc + f_data;
          n.remain = r.remain - 8'h01;
          // Oversized packets still drain but only the head is kept
          if (r.cnt < 8'(PAYLOAD_MAX)) begin
            n.pbuf[r.cnt[3:0]] = f_data;
          end
          if (r.cnt != 8'hFF) begin
            n.cnt = r.cnt + 8'h01;
          end
          if (r.remain == 8'h01) begin
            n.state = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        n.pend     = PEND_NONE;
        n.tx_valid = 1'b1;
        n.state    = S_ACK;
        if (r.calc != r.sum) begin
          // Bad packet: no state of the command is touched
          n.tx_data = NAK_BYTE;
        end else begin
          // Good reception, whatever the command turns out to be
          n.tx_data = ACK_BYTE;
          n.status  = STAT_SUCCESS;
          unique case (cmd)
            CMD_PING: begin
              if (r.len != LEN_SHORT) n.status = STAT_BAD_SIZE;
            end
            CMD_STATUS: begin
              if (r.len == LEN_SHORT) begin
                n.reply = r.status;
                n.pend  = PEND_REPLY;
              end else begin
                n.status = STAT_BAD_SIZE;
              end
            end
            CMD_DOWNLOAD: begin
              if (r.len == LEN_DOWNLOAD) begin
                n.prog_addr   = arg_a;
                n.prog_left   = arg_b;
                n.dl_active   = (arg_b != 32'h0000_0000);
                n.flash_addr  = arg_a;
                n.flash_size  = arg_b;
                n.erase_valid = 1'b1;
                n.tx_valid    = 1'b0;
                n.state       = S_ERASE;
              end else begin
                n.status    = STAT_BAD_SIZE;
                n.dl_active = 1'b0;
              end
            end
            CMD_DATA: begin
              if (!r.dl_active) begin
                n.status = STAT_INVALID;
              end else if (nbytes > DATA_MAX) begin
                n.status = STAT_BAD_SIZE;
              end else if (32'(nbytes) > r.prog_left) begin
                n.status = STAT_BAD_SIZE;
              end else if (nbytes != 8'h00) begin
                n.pend = PEND_PROG;
              end
            end
            CMD_RUN: begin
              if (r.len == LEN_RUN) begin
                n.run_addr = arg_a;
                n.pend     = PEND_RUN;
              end else begin
                n.status = STAT_BAD_SIZE;
              end
            end
            CMD_RESET: begin
              if (r.len == LEN_SHORT) n.pend = PEND_RST;
              else n.status = STAT_BAD_SIZE;
            end
            default: n.status = STAT_UNKNOWN;
          endcase
        end
      end
      S_ERASE: begin
        // Acknowledge held back until the erase completes
        if (i_flash_done) begin
          n.erase_valid = 1'b0;
          n.tx_valid    = 1'b1;
          n.tx_data     = ACK_BYTE;
          n.state       = S_ACK;
        end
      end
      S_ACK: begin
        if (i_tx_ready) begin
          n.tx_valid = 1'b0;
          n.state    = S_IDLE;
          unique case (r.pend)
            PEND_PROG: begin
              n.prog_idx   = 8'h01;
              n.prog_valid = 1'b1;
              n.flash_addr = r.prog_addr;
              n.prog_data  = r.pbuf[1];
              n.state      = S_PROG;
            end
            PEND_RUN: n.run_valid = 1'b1;
            PEND_RST: n.soft_reset = 1'b1;
            PEND_REPLY: begin
              n.tx_valid = 1'b1;
              n.tx_data  = LEN_SHORT;
              n.rep_idx  = 2'd0;
              n.state    = S_REPLY;
            end
            default: n.pend = PEND_NONE;
          endcase
        end
      end
      S_PROG: begin
        // Address advances only for bytes of an accepted packet
        if (i_flash_done) begin
          n.prog_addr = r.prog_addr + 32'h0000_0001;
          n.prog_left = r.prog_left - 32'h0000_0001;
          if (r.prog_left == 32'h0000_0001) begin
            n.dl_active = 1'b0;
          end
          if (r.prog_idx == nbytes) begin
            n.prog_valid = 1'b0;
            n.state      = S_IDLE;
          end else begin
            n.prog_idx   = r.prog_idx + 8'h01;
            n.flash_addr = r.prog_addr + 32'h0000_0001;
            n.prog_data  = r.pbuf[4'(r.prog_idx + 8'h01)];
          end
        end
      end
      S_REPLY: begin
        // Next byte loads in the accept cycle so the packet has no gap
        if (i_tx_ready) begin
          n.rep_idx = r.rep_idx + 2'd1;
          if (r.rep_idx == 2'd2) begin
            n.tx_valid = 1'b0;
            n.state    = S_HOST_ACK;
          end else begin
            n.tx_data = r.reply;
          end
        end
      end
      S_HOST_ACK: begin
        // Either answer closes the exchange; a retry comes as a new command
        f_ready = 1'b1;
        if (f_valid && f_data != PAD_BYTE) begin
          n.state = S_IDLE;
        end
      end
      default: n.state = S_IDLE;
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.state    <= S_IDLE;
      r.status   <= STAT_RESET;
      r.pend     <= PEND_NONE;
      r.phase    <= CLOCK_PHASE;
      r.polarity <= CLOCK_POLARITY;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs, all taken from the state register
  assign o_tx_valid       = r.tx_valid;
  assign o_tx_data        = r.tx_data;
  assign o_erase_valid    = r.erase_valid;
  assign o_prog_valid     = r.prog_valid;
  assign o_flash_addr     = r.flash_addr;
  assign o_flash_size     = r.flash_size;
  assign o_prog_data      = r.prog_data;
  assign o_run_valid      = r.run_valid;
  assign o_run_addr       = r.run_addr;
  assign o_soft_reset     = r.soft_reset;
  assign o_clock_phase    = r.phase;
  assign o_clock_polarity = r.polarity;
  assign o_status         = r.status;

endmodule

// *** dv/sblp_loader_sva.sv ***
`timescale 1ns/100ps

module sblp_sva
  import sblp_pkg::*;
(
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  // Transmit side
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  // Flash, execution and port mode
  input wire logic        o_erase_valid,
  input wire logic        o_prog_valid,
  input wire logic [31:0] o_flash_addr,
  input wire logic [7:0]  o_prog_data,
  input wire logic        i_flash_done,
  input wire logic        o_run_valid,
  input wire logic        o_soft_reset,
  input wire logic        o_clock_phase,
  input wire logic        o_clock_polarity
);
  // ==========================================
  // Helpers
  logic       ack_go;
  logic [1:0] rel_cnt_r;
  assign ack_go = o_tx_valid && i_tx_ready && (o_tx_data == ACK_BYTE);
  // Edges since release; the port mode is loaded by reset, which the sync flops hold for two edges
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rel_cnt_r <= 2'd0;
    end else if (rel_cnt_r != 2'd3) begin
      rel_cnt_r <= rel_cnt_r + 2'd1;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // Properties
  sequence s_len_out;
    o_tx_valid && i_tx_ready && (o_tx_data == LEN_SHORT);
  endsequence
  sequence s_prog_step;
    (o_prog_valid && i_flash_done) ##1 o_prog_valid;
  endsequence
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  property p_reply_gap;
    s_len_out |=> o_tx_valid;
  endproperty
  property p_reply_sum;
    logic [7:0] v;
    s_len_out ##1 (o_tx_valid && i_tx_ready, v = o_tx_data) |=> o_tx_valid && o_tx_data == v;
  endproperty
  property p_erase_ack;
    o_erase_valid && i_flash_done |=> o_tx_valid && (o_tx_data == ACK_BYTE);
  endproperty
  property p_erase_quiet;
    o_erase_valid |-> !o_tx_valid;
  endproperty
  property p_prog_hold;
    o_prog_valid && !i_flash_done |=> o_prog_valid && $stable(o_flash_addr) && $stable(o_prog_data);
  endproperty
  property p_prog_addr;
    s_prog_step |-> o_flash_addr == $past(o_flash_addr) + 32'h0000_0001;
  endproperty
  property p_run_after_ack;
    $rose(o_run_valid) |-> ($past(ack_go) || $past(ack_go, 2)) ##1 !o_run_valid;
  endproperty
  property p_rst_after_ack;
    $rose(o_soft_reset) |-> ($past(ack_go) || $past(ack_go, 2)) ##1 !o_soft_reset;
  endproperty
  property p_port_mode;
    rel_cnt_r == 2'd3 |-> o_clock_phase == CLOCK_PHASE && o_clock_polarity == CLOCK_POLARITY;
  endproperty
  a_tx_hold:       assert property (p_tx_hold)
    else $error("transmit byte changed before it was taken");
  a_reply_gap:     assert property (p_reply_gap)
    else $error("gap after reply length byte");
  a_reply_sum:     assert property (p_reply_sum)
    else $error("reply payload differs from its sum byte");
  a_erase_ack:     assert property (p_erase_ack)
    else $error("no acknowledge right after erase");
  a_erase_quiet:   assert property (p_erase_quiet)
    else $error("byte sent while erasing");
  a_prog_hold:     assert property (p_prog_hold)
    else $error("program request changed before done");
  a_prog_addr:     assert property (p_prog_addr)
    else $error("program address not consecutive");
  a_run_after_ack: assert property (p_run_after_ack)
    else $error("run start not right after acknowledge");
  a_rst_after_ack: assert property (p_rst_after_ack)
    else $error("soft reset not right after acknowledge");
  a_port_mode:     assert property (p_port_mode)
    else $error("wrong synchronous port mode");
endmodule

bind sblp_loader sblp_sva sblp_sva_i (
  .i_clock          (i_clock),
  .i_rst_b          (i_rst_b),
  .o_tx_valid       (o_tx_valid),
  .o_tx_data        (o_tx_data),
  .i_tx_ready       (i_tx_ready),
  .o_erase_valid    (o_erase_valid),
  .o_prog_valid     (o_prog_valid),
  .o_flash_addr     (o_flash_addr),
  .o_prog_data      (o_prog_data),
  .i_flash_done     (i_flash_done),
  .o_run_valid      (o_run_valid),
  .o_soft_reset     (o_soft_reset),
  .o_clock_phase    (o_clock_phase),
  .o_clock_polarity (o_clock_polarity)
);

// *** dv/sblp_host_model.sv ***
`timescale 1ns/100ps

module sblp_host_model (
  // Clock, reset and pacing
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_slow,
  // Bytes towards the device
  output      logic       o_rx_valid,
  output      logic [7:0] o_rx_data,
  input  wire logic       i_rx_ready,
  // Bytes from the device
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output      logic       o_tx_ready,
  // Flash engine stand-in
  input  wire logic       i_flash_req,
  output      logic       o_flash_done
);
  logic [7:0] send_q[$];
  logic [7:0] recv_q[$];
  logic [7:0] last_r = 8'h00;
  logic       taken;
  int         cyc = 0;
  int         wait_cnt = 0;
  // Idle values at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'hFF;
    o_tx_ready = 1'b0;
    o_flash_done = 1'b0;
  end
  // Sample on the edge, drive one step later so nothing races the device
  always @(posedge i_clock) begin
    taken = o_rx_valid && i_rx_ready;
    if (i_tx_valid && o_tx_ready && (i_tx_data != 8'h00)) begin
      recv_q.push_back(i_tx_data);
    end
    #1;
    cyc++;
    if (taken) begin
      last_r = send_q.pop_front();
    end
    // A raised valid stays until taken; slow mode leaves gaps between bytes
    o_rx_valid = i_rst_b && ((o_rx_valid && !taken) ||
                 (send_q.size() != 0 && !(i_slow && (cyc % 3 == 0))));
    // Idle data shows the inverse of the last byte, never a stale copy
    o_rx_data = o_rx_valid ? send_q[0] : ~last_r;
    o_tx_ready = !(i_slow && (cyc % 3 == 1));
    wait_cnt = (i_flash_req && !o_flash_done) ? wait_cnt + 1 : 0;
    o_flash_done = wait_cnt >= (i_slow ? 3 : 1);
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
  import sblp_pkg::*;
  // ==========================================
  // Clock, reset and wiring
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        baud_lock = 1'b0;
  logic        slow = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, flash_done, erase_v, prog_v;
  logic        run_v, soft_rst, phase, polarity;
  logic [7:0]  rx_data, tx_data, prog_data, status, v;
  logic [31:0] flash_addr, flash_size, run_addr, a;
  int          err_count = 0;
  int          comparisons = 0;
  int          rst_cnt = 0;
  integer      seed = 6;
  logic [39:0] prog_q[$];
  logic [63:0] erase_q[$];
  logic [31:0] run_q[$];
  logic [7:0]  p[$];
  logic [7:0]  codes[6] = '{CMD_PING, CMD_DOWNLOAD, CMD_RUN, CMD_STATUS, CMD_DATA, CMD_RESET};
  int          lens[6] = '{3, 11, 7, 3, 11, 3};

  always #10 clock = ~clock;

  sblp_loader sblp_loader_i (
    .i_clock(clock), .i_rst_b(rst_b), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .i_baud_lock(baud_lock), .o_erase_valid(erase_v),
    .o_prog_valid(prog_v), .o_flash_addr(flash_addr), .o_flash_size(flash_size),
    .o_prog_data(prog_data), .i_flash_done(flash_done), .o_run_valid(run_v),
    .o_run_addr(run_addr), .o_soft_reset(soft_rst), .o_clock_phase(phase),
    .o_clock_polarity(polarity), .o_status(status));
  sblp_host_model sblp_host_model_i (
    .i_clock(clock), .i_rst_b(rst_b), .i_slow(slow), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready), .i_flash_req(erase_v | prog_v),
    .o_flash_done(flash_done));

  // Record flash, run and reset events as the device completes them
  always @(posedge clock) begin
    if (prog_v && flash_done) prog_q.push_back({flash_addr, prog_data});
    if (erase_v && flash_done) erase_q.push_back({flash_addr, flash_size});
    if (run_v) run_q.push_back(run_addr);
    if (soft_rst) rst_cnt++;
  end

  // ==========================================
  // Tasks
  function automatic logic [7:0] sum8(input logic [7:0] q[$]);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s = s + q[i];
    return s;
  endfunction
  // Zero padding first; a bad flag flips the sum's low bit
  task automatic send_pkt(input logic [7:0] q[$], input logic bad);
    sblp_host_model_i.send_q.push_back(PAD_BYTE);
    sblp_host_model_i.send_q.push_back(8'(q.size() + 2));
    sblp_host_model_i.send_q.push_back(sum8(q) ^ {7'h00, bad});
    foreach (q[i]) sblp_host_model_i.send_q.push_back(q[i]);
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    int n = 0;
    while (sblp_host_model_i.recv_q.size() == 0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    v = (n < 400) ? sblp_host_model_i.recv_q.pop_front() : ~exp;
    `CHECK(v, exp)
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic host_ack(input logic [7:0] b);
    sblp_host_model_i.send_q.push_back(PAD_BYTE);
    sblp_host_model_i.send_q.push_back(b);
  endtask
  task automatic pkt_ack(input logic [7:0] q[$], input logic [7:0] exp);
    send_pkt(q, 1'b0);
    expect_byte(exp);
  endtask
  task automatic end_test(input string name);
    // Long enough for eight slow program steps to finish
    repeat (40) @(posedge clock);
    #1;
    $display("Test %s done at %0t", name, $time);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    `CHECK({phase, polarity}, {CLOCK_PHASE, CLOCK_POLARITY})
    // Every command with a broken sum is refused and does nothing
    foreach (codes[k]) begin
      p = '{codes[k]};
      repeat (lens[k] - 3) p.push_back(8'($random(seed)));
      send_pkt(p, 1'b1);
      expect_byte(NAK_BYTE);
    end
    end_test("bad_sum");
    `CHECK(status, STAT_RESET)
    `CHECK(erase_q.size() + run_q.size() + rst_cnt, 0)
    pkt_ack('{CMD_DATA, 8'h5A}, ACK_BYTE);
    `CHECK(status, STAT_INVALID)
    pkt_ack('{8'h7E}, ACK_BYTE);
    pkt_ack('{CMD_STATUS}, ACK_BYTE);
    expect_byte(LEN_SHORT);
    expect_byte(STAT_UNKNOWN);
    expect_byte(STAT_UNKNOWN);
    // Host refuses the reply and asks again; the query itself left success
    host_ack(NAK_BYTE);
    pkt_ack('{CMD_STATUS}, ACK_BYTE);
    expect_byte(LEN_SHORT);
    expect_byte(STAT_SUCCESS);
    expect_byte(STAT_SUCCESS);
    host_ack(ACK_BYTE);
    pkt_ack('{CMD_PING, 8'h00}, ACK_BYTE);
    `CHECK(status, STAT_BAD_SIZE)
    pkt_ack('{CMD_PING}, ACK_BYTE);
    `CHECK(status, STAT_SUCCESS)
    // A length below the header size is refused at once
    sblp_host_model_i.send_q.push_back(8'h01);
    expect_byte(NAK_BYTE);
    `CHECK(status, STAT_BAD_SIZE)
    end_test("status");
    // Download with a stalling host and slow flash
    slow = 1'b1;
    a = $random(seed);
    pkt_ack('{CMD_DOWNLOAD, a[31:24], a[23:16], a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h0A},
            ACK_BYTE);
    `CHECK(erase_q.pop_front(), {a, 32'h0000_000A})
    p = '{CMD_DATA};
    repeat (8) p.push_back(8'($random(seed)));
    pkt_ack(p, ACK_BYTE);
    end_test("data8");
    for (int i = 0; i < 8; i++) `CHECK(prog_q[i], {a + i, p[i + 1]})
    p = '{CMD_DATA, 8'($random(seed)), 8'($random(seed))};
    send_pkt(p, 1'b1);
    expect_byte(NAK_BYTE);
    end_test("nak");
    `CHECK(prog_q.size(), 8)
    pkt_ack(p, ACK_BYTE);
    end_test("resend");
    `CHECK(prog_q[8], {a + 8, p[1]})
    `CHECK(prog_q[9], {a + 9, p[2]})
    pkt_ack('{CMD_DATA, 8'hA5}, ACK_BYTE);
    end_test("overrun");
    `CHECK(prog_q.size(), 10)
    slow = 1'b0;
    // Baud pattern, run and reset
    baud_lock = 1'b1;
    @(posedge clock);
    #1 baud_lock = 1'b0;
    expect_byte(ACK_BYTE);
    a = $random(seed);
    pkt_ack('{CMD_RUN, a[31:24], a[23:16], a[15:8], a[7:0]}, ACK_BYTE);
    end_test("run");
    `CHECK(run_q.pop_front(), a)
    pkt_ack('{CMD_RESET}, ACK_BYTE);
    end_test("reset");
    `CHECK(rst_cnt, 1)
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #600000;
    err_count++;
    print_verdict();
  end
endmodule
